// File: hdl/fault_status_capture.sv
// fault status and fault address capture with sized register access
// Notes on behaviour
// RL1: unstack bus fault sets flag, no address
// RL2: stack bus fault sets flag, no address
// RL3: lazy save bus fault sets flag
// RL4: known-address bus fault sets valid; memory faults clear it
// RL5: handler clears bus valid after escalation
// RL6: undecodable instruction sets undefined flag
// RL7: illegal status use sets invalid state, except in a cycle that also has an undefined instruction
// RL8: bad return load sets invalid pc flag
// RL9: coprocessor access sets no-coprocessor flag
// RL10: misaligned flag gated by trap, multiples always
// RL11: zero divide flagged only when trap enabled
// RL12: usage flags sticky until one written
// RL13: word, halfword, byte views of combined register
// RL14: subregister bit ranges 7:0, 15:8, 31:16
// RL15: hard fault bits read normally, write-one-clear
// RL16: software writes zero to debug bit
// RL17: escalated configurable fault sets forced bit
// RL18: vector table bus fault sets table bit
// RL19: memory address holds fault location when valid
// RL20: split misaligned access captures actual address
// RL21: precise bus error captures bus fault address
// RL22: data access violation captures access address
// RL23: reset clears flags; reserved bits read zero
`timescale 1ns/100ps
`include "fault_status_consts.svh"
module fault_status_capture
   import fault_status_pkg::*;
(
   input wire logic clk_sys, // 20 MHz system clock
   input wire logic reset_n, // sync reset, active low
   // register access side
   input wire logic [31:0] bus_addr, // register byte address
   input wire logic [1:0] bus_size, // access size, access_size_t code
   input wire logic bus_wr, // write strobe, one cycle
   input wire logic bus_rd, // read strobe, one cycle
   input wire logic [31:0] bus_wdata, // write data, lane aligned to address
   output logic [31:0] bus_rdata, // read data, lane aligned
   output logic bus_rvalid, // read data valid pulse
   // fault reports from the core, one-cycle pulses
   input wire logic ev_iacc_viol, // instruction access violation
   input wire logic ev_data_access_violation, // data access violation
   input wire logic [31:0] ev_mem_addr, // actual faulting memory address
   input wire logic ev_mstack_err, // memory fault on stacking
   input wire logic ev_munstack_err, // memory fault on unstacking
   input wire logic ev_mlazy_err, // memory fault on lazy save
   input wire logic ev_ibus_err, // instruction bus error
   input wire logic ev_precise_bus_error, // precise data bus error
   input wire logic ev_imprecise_err, // imprecise data bus error
   input wire logic [31:0] ev_bus_addr, // faulting bus address
   input wire logic ev_stack_bus_error, // bus fault on stacking
   input wire logic ev_unstack_bus_error, // bus fault on unstacking
   input wire logic ev_lazy_save_bus_error, // bus fault on lazy save
   input wire logic ev_undefined_instruction, // undecodable instruction
   input wire logic ev_invalid_state, // illegal status word use
   input wire logic ev_invalid_pc_load, // bad return value load
   input wire logic ev_coprocessor, // coprocessor access attempt
   input wire logic ev_misaligned, // misaligned single access
   input wire logic ev_misaligned_multi, // misaligned multiple or double
   input wire logic ev_zero_divide, // divide with zero divisor
   input wire logic ev_escalated, // configurable fault forced to hard
   input wire logic ev_vector_table, // bus fault on vector read
   // registered status and control views
   output logic [31:0] configurable_fault_status, // combined status, registered
   output logic [31:0] hard_fault_status, // hard fault status, registered
   output logic misaligned_trap_enable, // trap enable, registered
   output logic zero_divide_trap_enable // trap enable, registered
);
   logic [31:0] cfsr_r, cfsr_nxt;
   logic [31:0] hfsr_r, hfsr_nxt;
   logic [31:0] bfar_r, bfar_nxt;
   logic [31:0] ccr_r, ccr_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [31:0] mmfar_q;
   logic mmfar_load;
   logic [31:0] mmfar_data;
   logic [31:0] cfsr_set; // hardware set terms, combined status
   logic [31:0] cfsr_clr; // software clear terms, combined status
   logic [31:0] hfsr_set; // hardware set terms, hard status
   logic [31:0] hfsr_clr; // software clear terms, hard status
   logic [31:0] wr_lane; // bit mask of the accessed byte lanes
   logic cfsr_wr; // write aimed at combined status
   logic hfsr_wr; // write aimed at hard status
   logic mmfar_wr; // write aimed at memory fault address
   logic bfar_wr; // write aimed at bus fault address
   logic ccr_wr; // write aimed at control

   // byte lane mask for size and low address bits
   function automatic logic [3:0] lanes(input logic [1:0] sz, input logic [1:0] lo);
      logic [3:0] m;
      m = 4'h0;
      unique case (sz)
         SZ_BYTE: m = 4'(4'h1 << lo);
         SZ_HALF: m = lo[1] ? 4'hC : 4'h3;
         SZ_WORD: m = 4'hF;
         SZ_NONE: m = 4'h0;
      endcase
      return m;
   endfunction

   // whole-register match ignoring low two bits
   function automatic logic hit(input logic [31:0] a, input logic [31:0] base);
      return a[31:2] == base[31:2];
   endfunction

   // lane merge for partial writes of a plain read/write word
   function automatic logic [31:0] merge(input logic [31:0] cur, input logic [31:0] wd,
         input logic [31:0] m);
      return (cur & ~m) | (wd & m);
   endfunction

   // expand lane mask into bit mask
   always_comb begin
      logic [3:0] l;
      l = lanes(bus_size, bus_addr[1:0]);
      wr_lane = {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}}; // RL13
   end

   // write decode, one strobe per register
   always_comb begin
      cfsr_wr = bus_wr & hit(bus_addr, `CFSR_ADDR);
      hfsr_wr = bus_wr & hit(bus_addr, `HFSR_ADDR);
      mmfar_wr = bus_wr & hit(bus_addr, `MMFAR_ADDR);
      bfar_wr = bus_wr & hit(bus_addr, `BFAR_ADDR);
      ccr_wr = bus_wr & hit(bus_addr, `CCR_ADDR);
   end

   // hardware set terms for combined status
   always_comb begin
      cfsr_set = 32'h00000000;
      // memory management part
      cfsr_set[`BIT_IACC] = ev_iacc_viol;
      cfsr_set[`BIT_DACC] = ev_data_access_violation;
      cfsr_set[`BIT_MUNSTK] = ev_munstack_err;
      cfsr_set[`BIT_MSTK] = ev_mstack_err;
      cfsr_set[`BIT_MLSP] = ev_mlazy_err;
      cfsr_set[`BIT_MEM_ADDR_VALID] = ev_data_access_violation; // RL19
      // bus part
      cfsr_set[`BIT_IBUS] = ev_ibus_err;
      cfsr_set[`BIT_PRECISE] = ev_precise_bus_error;
      cfsr_set[`BIT_IMPRECISE] = ev_imprecise_err;
      cfsr_set[`BIT_UNSTK] = ev_unstack_bus_error; // RL1
      cfsr_set[`BIT_STK] = ev_stack_bus_error; // RL2
      cfsr_set[`BIT_LSP] = ev_lazy_save_bus_error; // RL3
      cfsr_set[`BIT_BUS_ADDR_VALID] = ev_precise_bus_error; // RL4
      // usage part
      cfsr_set[`BIT_UNDEF] = ev_undefined_instruction; // RL6
      cfsr_set[`BIT_BAD_STATE] = ev_invalid_state & ~ev_undefined_instruction; // RL7
      cfsr_set[`BIT_BAD_RETURN] = ev_invalid_pc_load; // RL8
      cfsr_set[`BIT_NO_COPROC] = ev_coprocessor; // RL9
      cfsr_set[`BIT_UNALIGN] = (ev_misaligned & ccr_r[`CTRL_BIT_MISALIGN_TRAP])
         | ev_misaligned_multi; // RL10
      cfsr_set[`BIT_DIVZERO] = ev_zero_divide & ccr_r[`CTRL_BIT_ZERO_DIV_TRAP]; // RL11
   end

   // software clear terms, write one to clear, reserved bits ignored
   always_comb begin
      cfsr_clr = cfsr_wr ? (bus_wdata & wr_lane & `CFSR_IMPL_MASK) : 32'h00000000; // RL12
      hfsr_clr = hfsr_wr ? (bus_wdata & wr_lane & `HFSR_IMPL_MASK) : 32'h00000000; // RL15
   end

   // hardware set terms for hard status
   always_comb begin
      hfsr_set = 32'h00000000;
      hfsr_set[`BIT_FORCED] = ev_escalated; // RL17
      hfsr_set[`BIT_VECTOR_READ] = ev_vector_table; // RL18
   end

   // combined status: sticky, set beats clear, memory fault drops bus valid
   always_comb begin
      logic mem_fault;
      mem_fault = ev_iacc_viol | ev_data_access_violation | ev_mstack_err
         | ev_munstack_err | ev_mlazy_err;
      cfsr_nxt = (cfsr_r & ~cfsr_clr) | cfsr_set; // RL12
      if (mem_fault && !ev_precise_bus_error) begin
         cfsr_nxt[`BIT_BUS_ADDR_VALID] = 1'b0; // RL4
      end
      cfsr_nxt = cfsr_nxt & `CFSR_IMPL_MASK; // RL23
   end

   // hard status: sticky, set beats clear
   always_comb begin
      hfsr_nxt = ((hfsr_r & ~hfsr_clr) | hfsr_set) & `HFSR_IMPL_MASK; // RL15
   end

   // bus fault address: precise capture wins over software write
   always_comb begin
      bfar_nxt = bfar_r;
      if (ev_precise_bus_error) begin
         bfar_nxt = ev_bus_addr; // RL21
      end else if (bfar_wr) begin
         bfar_nxt = merge(bfar_r, bus_wdata, wr_lane);
      end
   end

   // control word, only the two trap enables are kept
   always_comb begin
      ccr_nxt = ccr_r;
      if (ccr_wr) begin
         ccr_nxt = merge(ccr_r, bus_wdata, wr_lane) & `CTRL_IMPL_MASK;
      end
   end

   // memory address load: capture wins over software write
   always_comb begin
      mmfar_load = 1'b0;
      mmfar_data = mmfar_q;
      if (ev_data_access_violation) begin
         mmfar_load = 1'b1;
         mmfar_data = ev_mem_addr; // RL22 RL20
      end else if (mmfar_wr) begin
         mmfar_load = 1'b1;
         mmfar_data = merge(mmfar_q, bus_wdata, wr_lane);
      end
   end

   // read path, lanes outside access read zero
   always_comb begin
      logic [31:0] w;
      w = 32'h00000000;
      if (hit(bus_addr, `CFSR_ADDR)) begin
         w = cfsr_r; // RL14
      end else if (hit(bus_addr, `HFSR_ADDR)) begin
         w = hfsr_r;
      end else if (hit(bus_addr, `MMFAR_ADDR)) begin
         w = mmfar_q;
      end else if (hit(bus_addr, `BFAR_ADDR)) begin
         w = bfar_r;
      end else if (hit(bus_addr, `CCR_ADDR)) begin
         w = ccr_r;
      end
      rvalid_nxt = bus_rd;
      rdata_nxt = bus_rd ? (w & wr_lane) : rdata_r; // RL13
   end

   // combined status register
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         cfsr_r <= `WORD_RESET; // RL23
      end else begin
         cfsr_r <= cfsr_nxt;
      end
   end

   // hard status register
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         hfsr_r <= `WORD_RESET; // RL23
      end else begin
         hfsr_r <= hfsr_nxt;
      end
   end

   // bus fault address register
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         bfar_r <= `WORD_RESET;
      end else begin
         bfar_r <= bfar_nxt;
      end
   end

   // control register
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         ccr_r <= `CCR_RESET;
      end else begin
         ccr_r <= ccr_nxt;
      end
   end

   // read port registers, data holds until the next read
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         rdata_r <= `WORD_RESET;
         rvalid_r <= 1'b0;
      end else begin
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
      end
   end

   // memory fault address lives in its own storage module
   fault_addr_store u_mmfar (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .load(mmfar_load),
      .load_data(mmfar_data),
      .rd_data(mmfar_q)
   );

   // every output comes straight from a register
   assign bus_rdata = rdata_r;
   assign bus_rvalid = rvalid_r;
   assign configurable_fault_status = cfsr_r;
   assign hard_fault_status = hfsr_r;
   assign misaligned_trap_enable = ccr_r[`CTRL_BIT_MISALIGN_TRAP];
   assign zero_divide_trap_enable = ccr_r[`CTRL_BIT_ZERO_DIV_TRAP];
endmodule

// File: include/fault_status_consts.svh
// offsets, field positions, reset values for fault status capture
`ifndef FAULT_STATUS_CONSTS_SVH
`define FAULT_STATUS_CONSTS_SVH
`define CFSR_ADDR 32'hE000ED28
`define CFSR_ADDR_B1 32'hE000ED29
`define CFSR_ADDR_H1 32'hE000ED2A
`define HFSR_ADDR 32'hE000ED2C
`define MMFAR_ADDR 32'hE000ED34
`define BFAR_ADDR 32'hE000ED38
`define CCR_ADDR 32'hE000ED14
`define BIT_IACC 0
`define BIT_DACC 1
`define BIT_MUNSTK 3
`define BIT_MSTK 4
`define BIT_MLSP 5
`define BIT_MEM_ADDR_VALID 7
`define BIT_IBUS 8
`define BIT_PRECISE 9
`define BIT_IMPRECISE 10
`define BIT_UNSTK 11
`define BIT_STK 12
`define BIT_LSP 13
`define BIT_BUS_ADDR_VALID 15
`define BIT_UNDEF 16
`define BIT_BAD_STATE 17
`define BIT_BAD_RETURN 18
`define BIT_NO_COPROC 19
`define BIT_UNALIGN 24
`define BIT_DIVZERO 25
`define BIT_VECTOR_READ 1
`define BIT_FORCED 30
`define BIT_DEBUG_RES 31
`define CTRL_BIT_MISALIGN_TRAP 3
`define CTRL_BIT_ZERO_DIV_TRAP 4
`define CTRL_IMPL_MASK 32'h00000018
`define CFSR_IMPL_MASK 32'h030FBFBB
`define HFSR_IMPL_MASK 32'hC0000002
`define WORD_RESET 32'h00000000
`define CCR_RESET 32'h00000000
`endif

// File: include/fault_status_pkg.sv
// types shared by the fault status capture block
package fault_status_pkg;
   typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD, SZ_NONE} access_size_t;
endpackage

// File: hdl/fault_addr_store.sv
// single word address holding register, loaded by capture or software write
`timescale 1ns/100ps
module fault_addr_store (
   input wire logic clk_sys, // system clock
   input wire logic reset_n, // sync reset, active low
   input wire logic load, // capture strobe
   input wire logic [31:0] load_data, // word to store
   output logic [31:0] rd_data // stored word, registered
);
   logic [31:0] word_r;
   logic [31:0] word_nxt;

   // next value selection
   always_comb begin
      word_nxt = word_r;
      if (load) begin
         word_nxt = load_data;
      end
   end

   // storage register
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         word_r <= `WORD_RESET;
      end else begin
         word_r <= word_nxt;
      end
   end

   assign rd_data = word_r;
endmodule

// File: tb/fault_status_capture_chk.sv
// timing checker for the fault status capture block
`timescale 1ns/100ps
module fault_status_capture_chk (
   input wire logic clk_sys, // clock
   input wire logic reset_n, // reset
   input wire logic bus_wr, // write strobe
   input wire logic ev_iacc_viol, // event
   input wire logic ev_precise_bus_error, // event
   input wire logic ev_stack_bus_error, // event
   input wire logic ev_unstack_bus_error, // event
   input wire logic ev_undefined_instruction, // event
   input wire logic ev_invalid_state, // event
   input wire logic ev_misaligned, // event
   input wire logic ev_misaligned_multi, // event
   input wire logic ev_zero_divide, // event
   input wire logic ev_escalated, // event
   input wire logic ev_vector_table, // event
   input wire logic [31:0] configurable_fault_status, // status
   input wire logic [31:0] hard_fault_status, // status
   input wire logic misaligned_trap_enable, // control
   input wire logic zero_divide_trap_enable // control
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // short views and the set conditions of the gated flags
   wire [31:0] cfs = configurable_fault_status;
   wire [31:0] hfs = hard_fault_status;
   wire mis_set = ev_misaligned_multi | (ev_misaligned & misaligned_trap_enable);
   wire dz_set = ev_zero_divide & zero_divide_trap_enable;
   wire inv_set = ev_invalid_state & ~ev_undefined_instruction;
   AST_UNSTACK: assert property (ev_unstack_bus_error |=> cfs[11])
      else $error("unstack flag not set");
   AST_STACK: assert property (ev_stack_bus_error |=> cfs[12])
      else $error("stack flag not set");
   AST_BUS_VALID: assert property (ev_precise_bus_error |=> cfs[15] && cfs[9])
      else $error("precise error or address valid not set");
   AST_INVALID_STATE_FAULT: assert property (!cfs[17] |=> cfs[17] == $past(inv_set))
      else $error("invalid state flag wrong");
   AST_MISALIGN: assert property (!cfs[24] |=> cfs[24] == $past(mis_set))
      else $error("misaligned flag wrong");
   AST_DIVZERO: assert property (!cfs[25] |=> cfs[25] == $past(dz_set))
      else $error("zero divide flag wrong");
   AST_STICKY: assert property (!bus_wr |=>
      (($past(cfs) & ~cfs & 32'hFFFF7FFF) | ($past(hfs) & ~hfs)) == 32'h0)
      else $error("flag dropped without a write");
   AST_FORCED: assert property (ev_escalated |=> hfs[30])
      else $error("forced bit not set");
   AST_VECT: assert property (ev_vector_table |=> hfs[1])
      else $error("vector table bit not set");
   AST_RSVD: assert property (!(cfs & ~32'h030FBFBB) && !(hfs & ~32'h40000002))
      else $error("reserved status bit set");
   // main scenarios
   cover property (ev_precise_bus_error ##1 ev_iacc_viol);
   cover property (ev_misaligned && !misaligned_trap_enable);
   cover property (ev_invalid_state && ev_undefined_instruction);
endmodule
bind fault_status_capture fault_status_capture_chk chk (.*);

// File: tb/fault_status_capture_tb.sv
// self-checking bench for the fault status capture block
`timescale 1ns/100ps
module fault_status_capture_tb;
   import fault_status_pkg::*;
   localparam logic [31:0] STAT = 32'hE000ED28;
   localparam logic [31:0] HARD = 32'hE000ED2C;
   localparam logic [31:0] CTRL = 32'hE000ED14;
   // expected {hard, combined} status after each lone event, traps on
   localparam logic [63:0] EXP_TAB [20] = '{64'h1, 64'h82, 64'h10, 64'h8, 64'h20, 64'h100,
      64'h8200, 64'h400, 64'h1000, 64'h800, 64'h2000, 64'h10000, 64'h20000, 64'h40000,
      64'h80000, 64'h1000000, 64'h1000000, 64'h2000000, 64'h40000000_00000000, 64'h2_00000000};
   logic clk_sys, bus_rvalid, misaligned_trap_enable, zero_divide_trap_enable;
   logic reset_n = 0, bus_wr = 0, bus_rd = 0;
   logic [1:0] bus_size = 2'h2;
   logic [31:0] bus_addr = '0, bus_wdata = '0, bus_rdata;
   logic [31:0] ev_mem_addr = 32'h20001003, ev_bus_addr = 32'h40000010;
   logic [31:0] configurable_fault_status, hard_fault_status;
   logic [19:0] ev = '0;
   int miscompares, samples_checked, cycles;
   fault_status_capture dut (.*, .ev_iacc_viol(ev[0]), .ev_data_access_violation(ev[1]),
      .ev_mstack_err(ev[2]), .ev_munstack_err(ev[3]), .ev_mlazy_err(ev[4]),
      .ev_ibus_err(ev[5]), .ev_precise_bus_error(ev[6]), .ev_imprecise_err(ev[7]),
      .ev_stack_bus_error(ev[8]), .ev_unstack_bus_error(ev[9]),
      .ev_lazy_save_bus_error(ev[10]), .ev_undefined_instruction(ev[11]),
      .ev_invalid_state(ev[12]), .ev_invalid_pc_load(ev[13]), .ev_coprocessor(ev[14]),
      .ev_misaligned(ev[15]), .ev_misaligned_multi(ev[16]), .ev_zero_divide(ev[17]),
      .ev_escalated(ev[18]), .ev_vector_table(ev[19]));
   // 20 MHz clock
   initial begin
      clk_sys = 0;
      forever #25 clk_sys = ~clk_sys;
   end
   // cycle ceiling against a hang
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one bus cycle with events; strobes drop after the taking edge
   task automatic cyc(input logic [19:0] e, input logic w, input logic r,
         input logic [31:0] a, input access_size_t s, input logic [31:0] d);
      @(posedge clk_sys);
      #1;
      ev = e;
      bus_wr = w;
      bus_rd = r;
      bus_addr = a;
      bus_size = s;
      bus_wdata = d;
      @(posedge clk_sys);
      #1;
      ev = '0;
      bus_wr = 0;
      bus_rd = 0;
   endtask
   task automatic rdchk(input logic [31:0] a, input access_size_t s, input logic [31:0] exp);
      cyc('0, 0, 1, a, s, '0);
      chk({31'h0, bus_rvalid}, 32'h1);
      chk(bus_rdata, exp);
   endtask
   task automatic t_reset();
      chk(configurable_fault_status | hard_fault_status, 32'h0);
      chk({30'h0, misaligned_trap_enable, zero_divide_trap_enable}, 32'h0);
      rdchk(32'hE000ED00, SZ_WORD, 32'h0);
      $display("reset test done");
   endtask
   task automatic t_events();
      cyc('0, 1, 0, CTRL, SZ_WORD, 32'h18);
      rdchk(CTRL, SZ_WORD, 32'h18);
      chk({30'h0, misaligned_trap_enable, zero_divide_trap_enable}, 32'h3);
      for (int k = 0; k < 20; k++) begin
         cyc(20'h1 << k, 0, 0, STAT, SZ_WORD, '0);
         chk(configurable_fault_status, EXP_TAB[k][31:0]);
         rdchk(HARD, SZ_WORD, EXP_TAB[k][63:32]);
         cyc('0, 1, 0, STAT, SZ_WORD, 32'hFFFFFFFF);
         cyc('0, 1, 0, HARD, SZ_WORD, 32'h7FFFFFFF);
         chk(configurable_fault_status | hard_fault_status, 32'h0);
      end
      $display("event capture test done");
   endtask
   task automatic t_gates();
      cyc('0, 1, 0, CTRL, SZ_WORD, 32'h0);
      cyc(20'h28000, 0, 0, STAT, SZ_WORD, '0);
      chk(configurable_fault_status, 32'h0);
      cyc(20'h10000, 0, 0, STAT, SZ_WORD, '0);
      chk(configurable_fault_status, 32'h1000000);
      cyc(20'h01800, 0, 0, STAT, SZ_WORD, '0);
      chk(configurable_fault_status, 32'h1010000);
      cyc('0, 1, 0, STAT, SZ_WORD, 32'h01010000);
      $display("gating test done");
   endtask
   task automatic t_sized();
      cyc(20'h02902, 0, 0, STAT, SZ_WORD, '0);
      cyc('0, 1, 0, STAT, SZ_WORD, 32'h0);
      chk(configurable_fault_status, 32'h51082);
      rdchk(STAT, SZ_BYTE, 32'h82);
      rdchk(STAT + 1, SZ_BYTE, 32'h1000);
      rdchk(STAT, SZ_HALF, 32'h1082);
      rdchk(STAT + 2, SZ_HALF, 32'h50000);
      rdchk(32'hE000ED34, SZ_WORD, 32'h20001003);
      cyc('0, 1, 0, STAT + 2, SZ_HALF, 32'h0001FFFF);
      cyc('0, 1, 0, STAT + 1, SZ_BYTE, 32'hFFFF10FF);
      chk(configurable_fault_status, 32'h40082);
      cyc(20'h40, 0, 0, STAT, SZ_WORD, '0);
      chk(configurable_fault_status, 32'h48282);
      cyc(20'h1, 0, 0, STAT, SZ_WORD, '0);
      chk(configurable_fault_status, 32'h40283);
      ev_bus_addr = 32'h40000024;
      cyc(20'h40040, 0, 0, STAT, SZ_WORD, '0);
      chk(configurable_fault_status, 32'h48283);
      rdchk(32'hE000ED38, SZ_WORD, 32'h40000024);
      chk(hard_fault_status, 32'h40000000);
      cyc('0, 1, 0, STAT, SZ_WORD, 32'h00008000);
      chk(configurable_fault_status, 32'h40283);
      $display("sized access test done");
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // reset for 12 cycles, then the scenarios
   initial begin
      repeat (12) @(posedge clk_sys);
      #1;
      reset_n = 1;
      t_reset();
      t_events();
      t_gates();
      t_sized();
      tally_and_finish();
   end
endmodule
